// >>> hdl/byte_stream_if.sv
/*
 * valid/ready stream between the receive fifo and the interpreter.
 * assumes both ends share one clock.
 */
interface byte_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] in_data;
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] out_data;
	logic out_valid;
	logic out_ready;
	modport fifo (input in_data, input in_valid, output in_ready, output out_data, output out_valid, input out_ready);
	modport user (output in_data, output in_valid, input in_ready, input out_data, input out_valid, output out_ready);
endinterface

// >>> hdl/cmd_pkg.sv
/*
 * constants, strings and helpers for the text command interpreter.
 * assumes 8-bit ascii bytes on a 250 MHz system clock.
 */
package cmd_pkg;
	localparam int STR_W = 160;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_4 = 8'h34;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_O = 8'h4f;
	localparam logic [STR_W-1:0] COMMAND_PREFIX = "CMD+T";
	localparam logic [3:0] COMMAND_PREFIX_LEN = 4'h5;
	// reads RSP-T, first character in the low byte
	localparam logic [63:0] REPLY_PREFIX_RST = 64'h0000_0054_2d50_5352;
	localparam logic [3:0] REPLY_PREFIX_LEN_RST = 4'h5;
	localparam logic [3:0] ARG_MAX = 4'h8;
	localparam int NUM_PINS = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [STR_W-1:0] ESC_SEQ = "^#^$^%";
	localparam logic [2:0] ESC_LEN = 3'h6;
	localparam int NUM_KW = 7;
	localparam int KW_DIR = 0;
	localparam int KW_WRITE = 1;
	localparam int KW_READ = 2;
	localparam int KW_CONNECT = 3;
	localparam int KW_TEARDOWN = 4;
	localparam int KW_BYPASS = 5;
	localparam int KW_CONFIG = 6;

	typedef enum logic [2:0] {
		BODY_OK, BODY_ERR, BODY_LOW, BODY_HIGH, BODY_UP, BODY_CLOSED, BODY_BYPASS, BODY_CMD
	} body_t;

	function automatic logic [7:0] chr(input logic [STR_W-1:0] s, input logic [4:0] len, input logic [4:0] i);
		logic [4:0] k;
		k = 5'(len - 5'h1 - i);
		return s[8*k +: 8];
	endfunction

	function automatic logic [STR_W-1:0] kw_str(input int k);
		case (k)
			KW_DIR: return "PinDir";
			KW_WRITE: return "PinWrite";
			KW_READ: return "PinRead";
			KW_CONNECT: return "SPPConnect";
			KW_TEARDOWN: return "SPPDisconnect";
			KW_BYPASS: return "Bypass";
			default: return "config";
		endcase
	endfunction

	function automatic logic [4:0] kw_len(input int k);
		case (k)
			KW_DIR: return 5'd6;
			KW_WRITE: return 5'd8;
			KW_READ: return 5'd7;
			KW_CONNECT: return 5'd10;
			KW_TEARDOWN: return 5'd13;
			KW_BYPASS: return 5'd6;
			default: return 5'd6;
		endcase
	endfunction

	function automatic logic [STR_W-1:0] body_str(input body_t b);
		case (b)
			BODY_OK: return "OK";
			BODY_ERR: return "ERROR";
			BODY_LOW: return "0";
			BODY_HIGH: return "1";
			BODY_UP: return "ConnectionUp";
			BODY_CLOSED: return "SPPConnectionClosed";
			BODY_BYPASS: return "-BypassMode-";
			default: return "-CommandMode-";
		endcase
	endfunction

	function automatic logic [4:0] body_len(input body_t b);
		case (b)
			BODY_OK: return 5'd2;
			BODY_ERR: return 5'd5;
			BODY_LOW: return 5'd1;
			BODY_HIGH: return 5'd1;
			BODY_UP: return 5'd12;
			BODY_CLOSED: return 5'd19;
			BODY_BYPASS: return 5'd12;
			default: return 5'd13;
		endcase
	endfunction
endpackage

// >>> hdl/rx_fifo.sv
/*
 * small synchronous fifo with registered full flag.
 * assumes a single clock; depth is a power of two.
 */
module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	byte_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] count_ff;
	logic not_full_ff;
	wire push = s.in_valid && not_full_ff;
	wire pop = s.out_valid && s.out_ready;
	wire [AW:0] nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

	assign s.in_ready = not_full_ff;
	assign s.out_valid = (count_ff != '0);
	assign s.out_data = mem_ff[rd_ff];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= s.in_data;
		end
	end

	// full flag is a flop so the ready pin never sees a combinational path
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			count_ff <= '0;
			not_full_ff <= 1'b1;
		end else begin
			wr_ff <= wr_ff + AW'(push);
			rd_ff <= rd_ff + AW'(pop);
			count_ff <= nxt_count;
			not_full_ff <= (nxt_count != (AW+1)'(DEPTH));
		end
	end
endmodule

// >>> hdl/text_command_gpio_interpreter.sv
/*
 * line based text command interpreter with four led pins and one link.
 * assumes a serial byte receiver and transmitter outside, on clk_i.
 */
module text_command_gpio_interpreter (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] link_data_o,
	output logic link_valid_o,
	output logic link_active_o,
	output logic bypass_o,
	input wire logic [cmd_pkg::NUM_PINS-1:0] gpio_i,
	output logic [cmd_pkg::NUM_PINS-1:0] gpio_o,
	output logic [cmd_pkg::NUM_PINS-1:0] gpio_oe_n_o
);
	import cmd_pkg::*;

	typedef enum logic [2:0] {PS_LEAD, PS_PFX, PS_KW, PS_ARG, PS_SKIP, PS_EXEC, PS_REPLY} state_t;

	byte_stream_if #(.WIDTH(8)) rx_s ();
	rx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (.clk_i(clk_i), .reset_i(reset_i), .s(rx_s.fifo));
	assign rx_s.in_data = rx_data_i;
	assign rx_s.in_valid = rx_valid_i;
	assign rx_ready_o = rx_s.in_ready;

	state_t state_ff;
	logic [4:0] pos_ff;
	logic [NUM_KW-1:0] alive_ff;
	logic [NUM_KW-1:0] hit_ff;
	logic [7:0][7:0] arg_ff;
	logic [3:0] arg_len_ff;
	logic bad_ff;
	logic [7:0][7:0] rp_ff;
	logic [3:0] rp_len_ff;
	body_t body_ff;
	logic [5:0] ridx_ff;
	logic [2:0] esc_ff;
	logic [NUM_PINS-1:0] sync1_ff;
	logic [NUM_PINS-1:0] sync2_ff;
	logic [NUM_PINS-1:0] cfg_ff;

	// bytes are held back while a reply drains, so the fifo takes the slack
	wire busy = (state_ff == PS_EXEC) || (state_ff == PS_REPLY);
	assign rx_s.out_ready = !busy;
	wire take = rx_s.out_valid && !busy;
	wire [7:0] c = rx_s.out_data;
	wire is_cr = (c == CH_CR);
	wire is_sp = (c == CH_SP);
	// leading spaces and old lines leave pos_ff anywhere, so lead compares char 0
	wire [4:0] pfx_pos = (state_ff == PS_LEAD) ? 5'h0 : pos_ff;
	wire pfx_match = (c == chr(COMMAND_PREFIX, 5'(COMMAND_PREFIX_LEN), pfx_pos));

	logic [NUM_KW-1:0] kw_step;
	logic [NUM_KW-1:0] kw_done;
	always_comb begin
		for (int k = 0; k < NUM_KW; k++) begin
			kw_step[k] = alive_ff[k] && (pos_ff < kw_len(k)) && (c == chr(kw_str(k), kw_len(k), pos_ff));
			kw_done[k] = alive_ff[k] && (pos_ff == kw_len(k));
		end
	end

	// command decode
	wire [7:0] pin_ch = arg_ff[0];
	wire pin_ok = (pin_ch >= CH_1) && (pin_ch <= CH_4);
	wire [1:0] pin = 2'(pin_ch - CH_1);
	wire two_args = (arg_len_ff == 4'h3) && (arg_ff[1] == CH_SP);
	wire [7:0] arg2 = arg_ff[2];
	wire dir_ok = pin_ok && two_args && ((arg2 == CH_I) || (arg2 == CH_O));
	wire wr_ok = pin_ok && two_args && cfg_ff[pin] && !gpio_oe_n_o[pin] && ((arg2 == CH_0) || (arg2 == CH_1));
	wire rd_ok = pin_ok && (arg_len_ff == 4'h1) && cfg_ff[pin];
	wire cfg_ok = (arg_len_ff != 4'h0) && !bad_ff;
	wire good = !bad_ff && (hit_ff != '0);
	wire do_dir = good && hit_ff[KW_DIR] && dir_ok;
	wire do_write = good && hit_ff[KW_WRITE] && wr_ok;
	wire do_read = good && hit_ff[KW_READ] && rd_ok;
	wire do_connect = good && hit_ff[KW_CONNECT] && !link_active_o && (arg_len_ff != 4'h0);
	wire do_teardown = good && hit_ff[KW_TEARDOWN] && link_active_o;
	wire do_bypass = good && hit_ff[KW_BYPASS] && link_active_o;
	wire do_config = good && hit_ff[KW_CONFIG] && cfg_ok;
	wire exec = (state_ff == PS_EXEC);

	body_t nxt_body;
	always_comb begin
		nxt_body = BODY_ERR;
		if (do_dir || do_write || do_config) begin
			nxt_body = BODY_OK;
		end else if (do_read) begin
			nxt_body = sync2_ff[pin] ? BODY_HIGH : BODY_LOW;
		end else if (do_connect) begin
			nxt_body = BODY_UP;
		end else if (do_teardown) begin
			nxt_body = BODY_CLOSED;
		end else if (do_bypass) begin
			nxt_body = BODY_BYPASS;
		end
	end

	// reply framing: prefix, space, body, cr, lf
	wire [5:0] p_end = 6'(rp_len_ff);
	wire [5:0] b_end = p_end + 6'h1 + 6'(body_len(body_ff));
	wire [5:0] r_last = b_end + 6'h1;
	wire [4:0] b_idx = 5'(ridx_ff - p_end - 6'h1);
	wire [7:0] r_char = (ridx_ff < p_end) ? rp_ff[ridx_ff[2:0]] :
		(ridx_ff == p_end) ? CH_SP :
		(ridx_ff < b_end) ? chr(body_str(body_ff), body_len(body_ff), b_idx) :
		(ridx_ff == b_end) ? CH_CR : CH_LF;
	wire tx_free = !tx_valid_o || tx_ready_i;
	wire r_load = (state_ff == PS_REPLY) && tx_free;
	wire esc_hit = bypass_o && take && (c == chr(ESC_SEQ, 5'(ESC_LEN), 5'(esc_ff)));
	wire esc_done = esc_hit && (esc_ff == 3'(ESC_LEN - 3'h1));

	state_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		if (exec) begin
			nxt_state = PS_REPLY;
		end else if (state_ff == PS_REPLY) begin
			// a started reply finishes even though the link just opened
			nxt_state = (tx_free && ridx_ff == r_last) ? PS_LEAD : PS_REPLY;
		end else if (bypass_o) begin
			nxt_state = esc_done ? PS_REPLY : PS_LEAD;
		end else if (take) begin
			unique case (state_ff)
				PS_LEAD: nxt_state = is_cr ? PS_EXEC : is_sp ? PS_LEAD : pfx_match ? PS_PFX : PS_SKIP;
				PS_PFX: nxt_state = is_cr ? PS_EXEC :
					(pos_ff == 5'(COMMAND_PREFIX_LEN)) ? (is_sp ? PS_KW : PS_SKIP) : pfx_match ? PS_PFX : PS_SKIP;
				PS_KW: nxt_state = is_cr ? PS_EXEC : is_sp ? PS_ARG : PS_KW;
				PS_ARG: nxt_state = is_cr ? PS_EXEC : PS_ARG;
				PS_SKIP: nxt_state = is_cr ? PS_EXEC : PS_SKIP;
				default: nxt_state = PS_LEAD;
			endcase
		end
	end

	wire nxt_bad = (state_ff == PS_LEAD) ? is_cr :
		(state_ff == PS_ARG) ? (bad_ff || (!is_cr && arg_len_ff == ARG_MAX)) :
		(state_ff == PS_KW) ? bad_ff : (nxt_state != PS_KW);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= PS_LEAD;
			pos_ff <= '0;
			alive_ff <= '0;
			hit_ff <= '0;
			arg_ff <= '0;
			arg_len_ff <= '0;
			bad_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (take && !bypass_o && !busy) begin
				bad_ff <= nxt_bad;
				pos_ff <= (state_ff == PS_PFX && pos_ff == 5'(COMMAND_PREFIX_LEN)) ? 5'h0 :
					(state_ff == PS_LEAD) ? 5'h1 : pos_ff + 5'(pos_ff != 5'h1f);
				alive_ff <= (state_ff == PS_KW) ? kw_step : '1;
				if (state_ff == PS_LEAD) begin
					hit_ff <= '0;
					arg_len_ff <= '0;
				end
				if (state_ff == PS_KW && (is_sp || is_cr)) begin
					hit_ff <= kw_done;
				end
				if (state_ff == PS_ARG && !is_cr && arg_len_ff != ARG_MAX) begin
					arg_ff[arg_len_ff[2:0]] <= c;
					arg_len_ff <= arg_len_ff + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rp_ff <= REPLY_PREFIX_RST;
			rp_len_ff <= REPLY_PREFIX_LEN_RST;
			body_ff <= BODY_OK;
			ridx_ff <= '0;
			tx_data_o <= '0;
			tx_valid_o <= 1'b0;
		end else begin
			if (exec && do_config) begin
				rp_ff <= arg_ff;
				rp_len_ff <= arg_len_ff;
			end
			if (exec) begin
				body_ff <= nxt_body;
				ridx_ff <= '0;
			end else if (esc_done) begin
				body_ff <= BODY_CMD;
				ridx_ff <= '0;
			end else if (r_load) begin
				ridx_ff <= ridx_ff + 6'h1;
			end
			if (r_load) begin
				tx_data_o <= r_char;
				tx_valid_o <= 1'b1;
			end else if (tx_ready_i) begin
				tx_valid_o <= 1'b0;
			end
		end
	end

	// link state and transparent path
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			link_active_o <= 1'b0;
			bypass_o <= 1'b0;
			link_data_o <= '0;
			link_valid_o <= 1'b0;
			esc_ff <= '0;
		end else begin
			if (exec && do_connect) begin
				link_active_o <= 1'b1;
			end else if (exec && do_teardown) begin
				link_active_o <= 1'b0;
			end
			if (exec && (do_connect || do_bypass)) begin
				bypass_o <= 1'b1;
			end else if (esc_done) begin
				bypass_o <= 1'b0;
			end
			link_valid_o <= bypass_o && take;
			if (bypass_o && take) begin
				link_data_o <= c;
			end
			if (!bypass_o || esc_done) begin
				esc_ff <= '0;
			end else if (take) begin
				esc_ff <= esc_hit ? esc_ff + 3'h1 : 3'((c == chr(ESC_SEQ, 5'(ESC_LEN), 5'h0)) ? 1 : 0);
			end
		end
	end

	// pins: oe_n low means driven; reset leaves all as undriven inputs
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			cfg_ff <= '0;
			gpio_o <= '0;
			gpio_oe_n_o <= '1;
		end else begin
			sync1_ff <= gpio_i;
			sync2_ff <= sync1_ff;
			if (exec && do_dir) begin
				cfg_ff[pin] <= 1'b1;
				gpio_oe_n_o[pin] <= (arg2 == CH_I);
			end
			if (exec && do_write) begin
				gpio_o[pin] <= (arg2 == CH_1);
			end
		end
	end
endmodule

// >>> tb/host_term.sv
/* host terminal model: sends text lines, collects reply bytes.
   assumes the interpreter samples on the rising edge of clk_i. */
module host_term (
	input wire logic clk_i,
	input wire logic rx_ready_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic stall = 1'b0;
	logic [7:0] got[$];
	initial begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// slow acceptance: ready every other cycle, none while stalled
	always @(posedge clk_i) tx_ready_o <= #1 !stall && !tx_ready_o;
	always @(negedge clk_i) if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
	task automatic send(input string s, input bit cr);
		for (int i = 0; i < s.len() + cr; i++) begin
			@(posedge clk_i);
			rx_data_o <= #1 (i < s.len()) ? s[i] : 8'h0d;
			rx_valid_o <= #1 1'b1;
			do @(negedge clk_i); while (!rx_ready_i);
		end
		@(posedge clk_i);
		rx_valid_o <= #1 1'b0;
		rx_data_o <= #1 ~rx_data_o;
	endtask
endmodule

// >>> tb/text_command_gpio_interpreter_sva.sv
/* port checker for the text command interpreter.
   assumes one clock and reset_i asynchronous, active high. */
module text_command_gpio_interpreter_sva (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic link_valid_o,
	input wire logic link_active_o,
	input wire logic bypass_o,
	input wire logic [3:0] gpio_o,
	input wire logic [3:0] gpio_oe_n_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
	property p_dir_reply; $changed(gpio_oe_n_o) |-> ##[1:4] tx_valid_o; endproperty
	a_dir_reply: assert property (p_dir_reply) else $error("direction change without reply");
	property p_write_out; ((gpio_o ^ $past(gpio_o)) & gpio_oe_n_o & $past(gpio_oe_n_o)) == 4'h0; endproperty
	a_write_out: assert property (p_write_out) else $error("input pin value changed");
	property p_connect; $rose(link_active_o) |-> bypass_o; endproperty
	a_connect: assert property (p_connect) else $error("link up outside transparent mode");
	property p_single_link; bypass_o |-> link_active_o; endproperty
	a_single_link: assert property (p_single_link) else $error("transparent without link");
	property p_fwd; link_valid_o |-> $past(bypass_o) || $past(bypass_o, 2); endproperty
	a_fwd: assert property (p_fwd) else $error("byte forwarded in command mode");
	property p_frozen; bypass_o && $past(bypass_o) |-> $stable(gpio_o) && $stable(gpio_oe_n_o); endproperty
	a_frozen: assert property (p_frozen) else $error("command run in transparent mode");
	// a carriage return in a reply is always followed by a line feed
	property p_cr_lf; tx_valid_o && tx_ready_i && tx_data_o == 8'h0d |=> ##[0:3] (tx_valid_o && tx_data_o == 8'h0a); endproperty
	a_cr_lf: assert property (p_cr_lf) else $error("reply not ended by line feed");
endmodule

// >>> tb/text_command_gpio_interpreter_tb.sv
/* self-checking bench for the text command interpreter.
   assumes host_term on the serial side and a 250 MHz clock. */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module text_command_gpio_interpreter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cmd_pkg::*;
	logic clk_i;
	logic reset_i;
	logic [7:0] rx_data, tx_data, link_data, b;
	logic rx_valid, rx_ready, tx_valid, tx_ready, link_valid, link_active, bypass;
	logic [3:0] gpio_in, gpio_out, gpio_oe_n;
	logic [7:0] lq[$];
	int err_count, checks, cycles;
	string cp, rp;
	text_command_gpio_interpreter text_command_gpio_interpreter_i (.clk_i(clk_i), .reset_i(reset_i),
		.rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
		.tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .link_data_o(link_data), .link_valid_o(link_valid),
		.link_active_o(link_active), .bypass_o(bypass), .gpio_i(gpio_in), .gpio_o(gpio_out), .gpio_oe_n_o(gpio_oe_n));
	host_term host_term_i (.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(negedge clk_i) if (link_valid) lq.push_back(link_data);
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic string kw(input int k);
		return string'(kw_str(k));
	endfunction
	task automatic expect_reply(input string body);
		string e;
		int n;
		e = {rp, " ", body, "\r\n"};
		n = 0;
		while (host_term_i.got.size() < e.len() && n < 600) begin
			@(posedge clk_i);
			n++;
		end
		for (int i = 0; i < e.len(); i++) begin
			b = (host_term_i.got.size() > 0) ? host_term_i.got.pop_front() : 8'hxx;
			`CHK(b, e[i])
		end
	endtask
	task automatic cmd(input string a, input string body);
		host_term_i.send({"  ", cp, " ", a}, 1'b1);
		expect_reply(body);
	endtask
	task automatic t_pins();
		cmd({kw(KW_WRITE), " 1 1"}, "ERROR");
		cmd({kw(KW_DIR), " 1 O"}, "OK");
		cmd({kw(KW_DIR), " 2 I"}, "OK");
		`CHK(gpio_oe_n, 4'he)
		cmd({kw(KW_WRITE), " 1 1"}, "OK");
		`CHK(gpio_out, 4'h1)
		cmd({kw(KW_WRITE), " 2 1"}, "ERROR");
		cmd({kw(KW_WRITE), " 1 0"}, "OK");
		`CHK(gpio_out, 4'h0)
		cmd({kw(KW_READ), " 2"}, "1");
		gpio_in <= #1 4'h0;
		cmd({kw(KW_READ), " 2"}, "0");
		cmd({kw(KW_READ), " 3"}, "ERROR");
		cmd("Nonsense", "ERROR");
	endtask
	task automatic t_fifo();
		host_term_i.stall = 1'b1;
		fork
			repeat (2) host_term_i.send({"  ", cp, " ", kw(KW_READ), " 2"}, 1'b1);
		join_none
		repeat (80) @(posedge clk_i);
		`CHK(rx_ready, 1'b0)
		host_term_i.stall = 1'b0;
		wait fork;
		expect_reply("0");
		expect_reply("0");
	endtask
	task automatic t_link();
		cmd({kw(KW_CONNECT), " 2"}, "ConnectionUp");
		`CHK(link_active & bypass, 1'b1)
		host_term_i.send("ab", 1'b1);
		repeat (20) @(posedge clk_i);
		`CHK({lq[0], lq[1], lq[2]}, 24'h61620d)
		`CHK(host_term_i.got.size(), 0)
		host_term_i.send("^#^$^%", 1'b0);
		expect_reply("-CommandMode-");
		`CHK({link_active, bypass}, 2'b10)
		cmd(kw(KW_BYPASS), "-BypassMode-");
		`CHK(bypass, 1'b1)
		host_term_i.send("^#^$^%", 1'b0);
		expect_reply("-CommandMode-");
		`CHK({link_active, bypass}, 2'b10)
		cmd({kw(KW_CONNECT), " 3"}, "ERROR");
		cmd(kw(KW_TEARDOWN), "SPPConnectionClosed");
		`CHK(link_active, 1'b0)
	endtask
	task automatic t_prefix();
		rp = ">>";
		cmd({kw(KW_CONFIG), " >>"}, "OK");
		host_term_i.send({">> ", kw(KW_READ), " 2"}, 1'b1);
		expect_reply("ERROR");
	endtask
	initial begin
		reset_i = 1'b1;
		gpio_in = 4'h2;
		cp = string'(COMMAND_PREFIX);
		rp = "";
		for (int i = 0; i < REPLY_PREFIX_LEN_RST; i++) rp = {rp, string'(REPLY_PREFIX_RST[8*i +: 8])};
		repeat (12) @(posedge clk_i);
		reset_i <= #1 1'b0;
		@(posedge clk_i);
		#1;
		`CHK({gpio_oe_n, gpio_out, link_active, bypass}, 10'h3c0)
		t_pins();
		t_fifo();
		t_link();
		t_prefix();
		report_and_stop();
	end
endmodule
bind text_command_gpio_interpreter text_command_gpio_interpreter_sva text_command_gpio_interpreter_sva_i (
	.clk_i(clk_i), .reset_i(reset_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
	.link_valid_o(link_valid_o), .link_active_o(link_active_o), .bypass_o(bypass_o), .gpio_o(gpio_o),
	.gpio_oe_n_o(gpio_oe_n_o));
